// [hw/radio_mode_state_control.sv]
// Operating-mode state machine of the packet transceiver with its control registers
`timescale 1ns/1ps
`default_nettype none

module radio_mode_state_control
    import radio_mode_pkg::*;
#(
    parameter int unsigned RETRY_STEP_CYCLES = 6250,
    parameter int unsigned ACK_TIMEOUT_CYCLES = 6250
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic radio_enable,
    input wire logic serial_select_low,
    input wire logic serial_clk,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe,
    input wire logic tx_fifo_empty,
    input wire logic tx_packet_done,
    input wire logic tx_skip_ack,
    input wire logic ack_received,
    input wire logic packet_received,
    input wire logic rx_skip_ack,
    output logic [2:0] radio_mode,
    output logic tx_active,
    output logic rx_active,
    output logic tx_is_retry,
    output logic max_retry_hit
);

    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        mode_t mode;
        logic [7:0] config_bits;
        logic [7:0] retry_bits;
        logic max_retry;
        logic [3:0] retry_counter;
        logic retry_wait;
        logic ack_wait;
        logic is_retry;
        logic [31:0] timer;
        logic [CE_COUNT_W-1:0] ce_count;
        logic ce_latched;
        logic pend_wr;
        logic [3:0] pend_addr;
        logic [7:0] pend_data;
        logic [7:0] rdata;
    } ctrl_state_t;

    ctrl_state_t cur_reg;
    ctrl_state_t cur_next;

    logic [3:0] spi_addr;
    logic [7:0] spi_wdata;
    logic spi_wr;
    logic spi_rd;
    logic [7:0] spi_rdata;

    function automatic logic [7:0] read_reg(input ctrl_state_t s, input logic [3:0] addr);
        logic [7:0] value;
        value = 8'h00;
        unique case (addr)
            CONFIG_OFFSET: value = s.config_bits;
            RETRY_OFFSET: value = s.retry_bits;
            STATUS_OFFSET:
            begin
                value[STATUS_MODE_LSB +: 3] = s.mode;
                value[STATUS_MAX_RETRY_POS] = s.max_retry;
                value[STATUS_COUNT_LSB +: 4] = s.retry_counter;
            end
            default: value = 8'h00;
        endcase
        return value;
    endfunction

    // The serial port runs off the system clock in every mode, power down included
    serial_port_slave u_serial (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .serial_select_low(cur_reg.sync2[PIN_SEL]),
        .serial_clk(cur_reg.sync2[PIN_SCLK]),
        .serial_data_in(cur_reg.sync2[PIN_SDATA]),
        .read_data(spi_rdata),
        .access_addr(spi_addr),
        .access_wdata(spi_wdata),
        .access_wr(spi_wr),
        .access_rd(spi_rd),
        .serial_data_out(serial_data_out),
        .serial_data_oe(serial_data_oe)
    );

    assign spi_rdata = read_reg(cur_reg, spi_addr);

    always_comb
    begin
        logic wr_en;
        logic [3:0] wr_addr;
        logic [7:0] wr_data;
        logic power_up;
        logic primary_receiver;
        logic auto_ack;
        logic ce;
        logic [31:0] delay_target;
        logic max_set;
        wr_en = 1'b0;
        wr_addr = 4'h0;
        wr_data = 8'h00;
        cur_next = cur_reg;
        max_set = 1'b0;
        cur_next.sync1 = {serial_data_in, serial_clk, serial_select_low, radio_enable};
        cur_next.sync2 = cur_reg.sync1;
        ce = cur_reg.sync2[PIN_CE];

        // Bus write wins a collision; the serial write is held until the first cycle without a bus write instead of being lost
        if (reg_wr)
        begin
            wr_en = 1'b1;
            wr_addr = reg_addr;
            wr_data = reg_wdata;
            if (spi_wr)
            begin
                cur_next.pend_wr = 1'b1;
                cur_next.pend_addr = spi_addr;
                cur_next.pend_data = spi_wdata;
            end
        end
        else if (cur_reg.pend_wr)
        begin
            wr_en = 1'b1;
            wr_addr = cur_reg.pend_addr;
            wr_data = cur_reg.pend_data;
            cur_next.pend_wr = spi_wr;
            cur_next.pend_addr = spi_addr;
            cur_next.pend_data = spi_wdata;
        end
        else if (spi_wr)
        begin
            wr_en = 1'b1;
            wr_addr = spi_addr;
            wr_data = spi_wdata;
        end

        if (wr_en && wr_addr == CONFIG_OFFSET)
        begin
            cur_next.config_bits = wr_data;
        end
        if (wr_en && wr_addr == RETRY_OFFSET)
        begin
            cur_next.retry_bits = wr_data;
        end
        if (wr_en && wr_addr == STATUS_OFFSET && wr_data[STATUS_MAX_RETRY_POS])
        begin
            cur_next.max_retry = 1'b0;
        end

        if (reg_rd)
        begin
            cur_next.rdata = read_reg(cur_reg, reg_addr);
        end

        power_up = cur_reg.config_bits[CFG_POWER_UP_POS];
        primary_receiver = cur_reg.config_bits[CFG_ROLE_POS];
        auto_ack = cur_reg.config_bits[CFG_AUTO_ACK_POS];
        delay_target = (32'(cur_reg.retry_bits[RETRY_DELAY_LSB +: 4]) + 32'h1)
            * RETRY_STEP_CYCLES;

        // Enable pulse qualifier only counts in standby-I
        if (cur_reg.mode == MODE_STANDBY_1 && !primary_receiver && ce)
        begin
            if (cur_reg.ce_count < CE_COUNT_W'(CE_PULSE_CYCLES))
            begin
                cur_next.ce_count = cur_reg.ce_count + 1'b1;
            end
            else
            begin
                cur_next.ce_latched = 1'b1;
            end
        end
        else
        begin
            cur_next.ce_count = '0;
        end

        unique case (cur_reg.mode)
            MODE_POWER_DOWN:
            begin
                if (power_up)
                begin
                    cur_next.mode = MODE_STANDBY_1;
                end
            end
            MODE_STANDBY_1:
            begin
                if (cur_reg.retry_wait && !auto_ack)
                begin
                    cur_next.retry_wait = 1'b0;
                end
                else if (cur_reg.retry_wait)
                begin
                    cur_next.timer = cur_reg.timer + 32'h1;
                    if (cur_reg.timer + 32'h1 >= delay_target)
                    begin
                        cur_next.retry_wait = 1'b0;
                        cur_next.timer = 32'h0;
                        if (cur_reg.retry_counter < cur_reg.retry_bits[RETRY_LIMIT_LSB +: 4])
                        begin
                            cur_next.retry_counter = cur_reg.retry_counter + 4'h1;
                            cur_next.is_retry = 1'b1;
                            cur_next.mode = MODE_TX;
                        end
                        else
                        begin
                            max_set = 1'b1;
                        end
                    end
                end
                else if (primary_receiver && ce)
                begin
                    cur_next.mode = MODE_RX;
                end
                else if (!primary_receiver && ce && tx_fifo_empty)
                begin
                    cur_next.mode = MODE_STANDBY_2;
                end
                else if (!primary_receiver && cur_next.ce_latched && !tx_fifo_empty)
                begin
                    cur_next.ce_latched = 1'b0;
                    cur_next.is_retry = 1'b0;
                    cur_next.retry_counter = 4'h0;
                    cur_next.mode = MODE_TX;
                end
            end
            MODE_STANDBY_2:
            begin
                if (!ce || primary_receiver)
                begin
                    cur_next.mode = MODE_STANDBY_1;
                end
                else if (!tx_fifo_empty)
                begin
                    cur_next.is_retry = 1'b0;
                    cur_next.retry_counter = 4'h0;
                    cur_next.mode = MODE_TX;
                end
            end
            MODE_TX:
            begin
                // Enable is only looked at once the packet on air has ended
                if (tx_packet_done)
                begin
                    cur_next.is_retry = 1'b0;
                    if (primary_receiver)
                    begin
                        cur_next.mode = ce ? MODE_RX : MODE_STANDBY_1;
                    end
                    else if (auto_ack && !tx_skip_ack)
                    begin
                        cur_next.ack_wait = 1'b1;
                        cur_next.timer = 32'h0;
                        cur_next.mode = MODE_RX;
                    end
                    else if (!ce)
                    begin
                        cur_next.mode = MODE_STANDBY_1;
                    end
                    else if (!tx_fifo_empty)
                    begin
                        cur_next.retry_counter = 4'h0;
                        cur_next.mode = MODE_TX;
                    end
                    else
                    begin
                        cur_next.mode = MODE_STANDBY_2;
                    end
                end
            end
            MODE_RX:
            begin
                if (primary_receiver || !cur_reg.ack_wait)
                begin
                    if (!ce)
                    begin
                        cur_next.mode = MODE_STANDBY_1;
                    end
                    else if (primary_receiver && packet_received && auto_ack && !rx_skip_ack)
                    begin
                        cur_next.mode = MODE_TX;
                    end
                end
                else if (!auto_ack)
                begin
                    cur_next.ack_wait = 1'b0;
                    cur_next.mode = MODE_STANDBY_1;
                end
                else if (ack_received)
                begin
                    cur_next.ack_wait = 1'b0;
                    cur_next.retry_counter = 4'h0;
                    if (!ce)
                    begin
                        cur_next.mode = MODE_STANDBY_1;
                    end
                    else if (!tx_fifo_empty)
                    begin
                        cur_next.mode = MODE_TX;
                    end
                    else
                    begin
                        cur_next.mode = MODE_STANDBY_2;
                    end
                end
                else if (cur_reg.timer + 32'h1 >= ACK_TIMEOUT_CYCLES)
                begin
                    cur_next.ack_wait = 1'b0;
                    cur_next.retry_wait = 1'b1;
                    cur_next.timer = 32'h0;
                    cur_next.mode = MODE_STANDBY_1;
                end
                else
                begin
                    cur_next.timer = cur_reg.timer + 32'h1;
                end
            end
            default:
            begin
                cur_next.mode = MODE_POWER_DOWN;
            end
        endcase

        // Power-up low overrides everything, even a packet in flight
        if (!power_up)
        begin
            cur_next.mode = MODE_POWER_DOWN;
            cur_next.retry_wait = 1'b0;
            cur_next.ack_wait = 1'b0;
            cur_next.is_retry = 1'b0;
            cur_next.ce_latched = 1'b0;
            cur_next.timer = 32'h0;
        end

        // A limit hit in the same cycle as a software clear stays set
        if (max_set)
        begin
            cur_next.max_retry = 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            cur_reg <= '0;
            cur_reg.sync1 <= PIN_IDLE;
            cur_reg.sync2 <= PIN_IDLE;
            cur_reg.mode <= MODE_POWER_DOWN;
            cur_reg.config_bits <= CONFIG_RESET;
            cur_reg.retry_bits <= RETRY_RESET;
        end
        else
        begin
            cur_reg <= cur_next;
        end
    end

    assign reg_rdata = cur_reg.rdata;
    assign radio_mode = cur_reg.mode;
    assign tx_active = (cur_reg.mode == MODE_TX);
    assign rx_active = (cur_reg.mode == MODE_RX);
    assign tx_is_retry = cur_reg.is_retry;
    assign max_retry_hit = cur_reg.max_retry;

endmodule
`default_nettype wire

// [hw/radio_mode_pkg.sv]
// Constants and types shared by the operating-mode controller and its serial port
package radio_mode_pkg;

    localparam int unsigned CLK_MHZ = 25;
    localparam int unsigned CE_PULSE_NS = 10000;
    localparam int unsigned CE_PULSE_CYCLES = (CE_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CE_COUNT_W = 9;

    localparam int unsigned REG_ADDR_W = 4;
    localparam int unsigned REG_DATA_W = 8;

    localparam logic [3:0] CONFIG_OFFSET = 4'h0;
    localparam logic [3:0] RETRY_OFFSET = 4'h1;
    localparam logic [3:0] STATUS_OFFSET = 4'h2;

    localparam int unsigned CFG_POWER_UP_POS = 0;
    localparam int unsigned CFG_ROLE_POS = 1;
    localparam int unsigned CFG_AUTO_ACK_POS = 2;
    localparam int unsigned RETRY_LIMIT_LSB = 0;
    localparam int unsigned RETRY_DELAY_LSB = 4;
    localparam int unsigned STATUS_MODE_LSB = 0;
    localparam int unsigned STATUS_MAX_RETRY_POS = 3;
    localparam int unsigned STATUS_COUNT_LSB = 4;

    localparam logic [7:0] CONFIG_RESET = 8'h04;
    localparam logic [7:0] RETRY_RESET = 8'h03;

    localparam int unsigned SPI_WRITE_POS = 7;
    localparam logic [4:0] SPI_CMD_LAST = 5'h07;
    localparam logic [4:0] SPI_FRAME_LAST = 5'h0F;
    localparam logic [4:0] SPI_FRAME_DONE = 5'h10;

    localparam int unsigned PIN_CE = 0;
    localparam int unsigned PIN_SEL = 1;
    localparam int unsigned PIN_SCLK = 2;
    localparam int unsigned PIN_SDATA = 3;
    localparam logic [3:0] PIN_IDLE = 4'h2;

    typedef enum logic [2:0] {
        MODE_POWER_DOWN = 3'b000,
        MODE_STANDBY_1 = 3'b001,
        MODE_STANDBY_2 = 3'b011,
        MODE_TX = 3'b010,
        MODE_RX = 3'b110
    } mode_t;

endpackage

// [hw/serial_port_slave.sv]
// Three-wire serial register port: command byte, then one data byte on a shared data line
`timescale 1ns/1ps
`default_nettype none

module serial_port_slave
    import radio_mode_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic serial_select_low,
    input wire logic serial_clk,
    input wire logic serial_data_in,
    input wire logic [7:0] read_data,
    output logic [3:0] access_addr,
    output logic [7:0] access_wdata,
    output logic access_wr,
    output logic access_rd,
    output logic serial_data_out,
    output logic serial_data_oe
);

    typedef struct packed {
        logic sclk_prev;
        logic [4:0] count;
        logic [7:0] cmd;
        logic [7:0] shift;
        logic wr;
        logic rd;
        logic oe;
        logic [7:0] wdata;
    } port_state_t;

    port_state_t cur_reg;
    port_state_t cur_next;

    always_comb
    begin
        logic rise;
        logic fall;
        logic [7:0] cmd_shifted;
        logic [7:0] data_shifted;
        rise = serial_clk && !cur_reg.sclk_prev;
        fall = !serial_clk && cur_reg.sclk_prev;
        cmd_shifted = {cur_reg.cmd[6:0], serial_data_in};
        data_shifted = {cur_reg.shift[6:0], serial_data_in};
        cur_next = cur_reg;
        cur_next.sclk_prev = serial_clk;
        cur_next.wr = 1'b0;
        cur_next.rd = 1'b0;
        if (serial_select_low)
        begin
            cur_next.count = 5'h00;
            cur_next.oe = 1'b0;
        end
        else
        begin
            // Read data is loaded one cycle after the request, long before the next falling edge
            if (cur_reg.rd)
            begin
                cur_next.shift = read_data;
                cur_next.oe = 1'b1;
            end
            else if (rise && cur_reg.count <= SPI_CMD_LAST)
            begin
                cur_next.cmd = cmd_shifted;
                cur_next.count = cur_reg.count + 5'h01;
                if (cur_reg.count == SPI_CMD_LAST && !cmd_shifted[SPI_WRITE_POS])
                begin
                    cur_next.rd = 1'b1;
                end
            end
            else if (rise && cur_reg.count < SPI_FRAME_DONE)
            begin
                cur_next.count = cur_reg.count + 5'h01;
                if (!cur_reg.oe)
                begin
                    cur_next.shift = data_shifted;
                end
                if (cur_reg.count == SPI_FRAME_LAST && cur_reg.cmd[SPI_WRITE_POS])
                begin
                    cur_next.wr = 1'b1;
                    cur_next.wdata = data_shifted;
                end
            end
            else if (fall && cur_reg.oe && cur_reg.count > SPI_CMD_LAST + 5'h01)
            begin
                cur_next.shift = {cur_reg.shift[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            cur_reg <= '0;
        end
        else
        begin
            cur_reg <= cur_next;
        end
    end

    assign access_addr = cur_reg.cmd[3:0];
    assign access_wdata = cur_reg.wdata;
    assign access_wr = cur_reg.wr;
    assign access_rd = cur_reg.rd;
    assign serial_data_out = cur_reg.shift[7];
    assign serial_data_oe = cur_reg.oe;

endmodule
`default_nettype wire

// [bench/radio_mode_monitor.sv]
// Port-level assertions for the operating-mode controller
`timescale 1ns/1ps
`default_nettype none
module radio_mode_monitor
    import radio_mode_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic radio_enable,
    input wire logic serial_select_low,
    input wire logic serial_data_oe,
    input wire logic tx_fifo_empty,
    input wire logic tx_packet_done,
    input wire logic ack_received,
    input wire logic packet_received,
    input wire logic rx_skip_ack,
    input wire logic [2:0] radio_mode,
    input wire logic max_retry_hit
);
    default clocking mon_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    AST_RESET: assert property ($rose(rst_b) |-> radio_mode == MODE_POWER_DOWN
        && reg_rdata == 8'h00 && !max_retry_hit) else $error("state not cleared by reset");
    AST_POWER_OFF: assert property (reg_wr && reg_addr == CONFIG_OFFSET
        && !reg_wdata[CFG_POWER_UP_POS] |-> ##2 radio_mode == MODE_POWER_DOWN)
        else $error("power down not entered");
    // Enable passes a synchroniser, so only a level held for several cycles is trusted
    AST_STANDBY_ONE: assert property (radio_mode == MODE_POWER_DOWN && reg_wr
        && reg_addr == CONFIG_OFFSET && reg_wdata[CFG_POWER_UP_POS] && !radio_enable
        && !$past(radio_enable) && !$past(radio_enable, 2) |-> ##2 radio_mode == MODE_STANDBY_1)
        else $error("standby-I not entered");
    AST_TX_FINISH: assert property ($past(radio_mode) == MODE_TX && radio_mode != MODE_TX
        && radio_mode != MODE_POWER_DOWN && !$past(reg_wr, 2) |-> $past(tx_packet_done))
        else $error("transmit left before packet end");
    AST_LOAD_TX: assert property (radio_mode == MODE_STANDBY_2 && !tx_fifo_empty
        && radio_enable && $past(radio_enable) && $past(radio_enable, 2) && $past(radio_enable, 3)
        && !$past(reg_wr) |=> radio_mode == MODE_TX) else $error("payload did not start transmit");
    AST_ACK_ONLY: assert property ($past(radio_mode) == MODE_RX && radio_mode == MODE_TX
        && !$past(reg_wr, 2) |-> $past(packet_received) && !$past(rx_skip_ack)
        || $past(ack_received)) else $error("receive left for transmit without ack duty");
    AST_LINE_FREE: assert property (serial_select_low && $past(serial_select_low)
        && $past(serial_select_low, 2) && $past(serial_select_low, 3) |-> !serial_data_oe)
        else $error("data line driven while deselected");
    AST_RETRY_STICKY: assert property (max_retry_hit && !(reg_wr
        && reg_addr == STATUS_OFFSET && reg_wdata[STATUS_MAX_RETRY_POS]) |=> max_retry_hit)
        else $error("retry flag dropped");
    AST_UNMAPPED: assert property (reg_rd && reg_addr > STATUS_OFFSET |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule
bind radio_mode_state_control radio_mode_monitor mon_u (.sys_clk, .rst_b, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .radio_enable, .serial_select_low, .serial_data_oe,
    .tx_fifo_empty, .tx_packet_done, .ack_received, .packet_received, .rx_skip_ack, .radio_mode,
    .max_retry_hit);
`default_nettype wire

// [bench/serial_host.sv]
// Host model driving the three-wire serial port
`timescale 1ns/1ps
`default_nettype none
module serial_host
    import radio_mode_pkg::*;
(
    output var logic serial_select_low,
    output var logic serial_clk,
    output var logic host_data,
    input wire logic line_level
);
    initial
    begin
        serial_select_low = 1'b1;
        serial_clk = 1'b0;
        host_data = 1'b0;
    end
    // 320 ns period stays under the 6 MHz ceiling; long low phase gives data setup margin
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wdat, output logic [7:0] rdat);
        logic [15:0] frame;
        frame = {cmd, wdat};
        rdat = 8'h00;
        #7;
        serial_select_low = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            // A released line toggles so a stale level never reads as valid data
            if (cmd[SPI_WRITE_POS] || i > 7)
                host_data = frame[i];
            else
                host_data = ~host_data;
            #200;
            serial_clk = 1'b1;
            if (i <= 7)
                rdat[i] = line_level;
            #120;
            serial_clk = 1'b0;
        end
        #200;
        serial_select_low = 1'b1;
        #640;
    endtask
endmodule
`default_nettype wire

// [bench/radio_mode_state_control_test.sv]
// Self-checking bench for the operating-mode controller
`timescale 1ns/1ps
`default_nettype none
module radio_mode_state_control_test
    import radio_mode_pkg::*;
;
    logic sys_clk, rst_b, reg_wr, reg_rd, radio_enable, tx_fifo_empty, tx_packet_done;
    logic tx_skip_ack, ack_received, packet_received, rx_skip_ack, serial_select_low;
    logic serial_clk, host_data, line_level, serial_data_out, serial_data_oe;
    logic tx_active, rx_active, tx_is_retry, max_retry_hit;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd;
    logic [2:0] radio_mode;
    int num_errors, compares, cycle_count;

    assign line_level = serial_data_oe ? serial_data_out : host_data;
    always #20 sys_clk = ~sys_clk;

    radio_mode_state_control #(.RETRY_STEP_CYCLES(4), .ACK_TIMEOUT_CYCLES(8)) dut_u (
        .sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .radio_enable,
        .serial_select_low, .serial_clk, .serial_data_in(line_level), .serial_data_out,
        .serial_data_oe, .tx_fifo_empty, .tx_packet_done, .tx_skip_ack, .ack_received,
        .packet_received, .rx_skip_ack, .radio_mode, .tx_active, .rx_active, .tx_is_retry,
        .max_retry_hit
    );
    serial_host host_u (.serial_select_low, .serial_clk, .host_data, .line_level);

    task automatic test_done();
        if (num_errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask
    // Bounded wait: the mode may settle a few cycles late through the synchronisers
    task automatic wait_mode(input logic [2:0] exp, input int max);
        #1;
        for (int n = 0; n < max && radio_mode !== exp; n++)
        begin
            @(posedge sys_clk);
            #1;
        end
        check({3'h0, tx_active, rx_active, radio_mode}, {3'h0, exp == MODE_TX, exp == MODE_RX, exp});
    endtask
    task automatic hold_mode(input logic [2:0] exp, input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            #1;
            check({5'h00, radio_mode}, {5'h00, exp});
        end
    endtask
    task automatic en_pulse(input int n);
        @(posedge sys_clk);
        radio_enable <= 1'b1;
        repeat (n) @(posedge sys_clk);
        radio_enable <= 1'b0;
    endtask
    task automatic done_pulse();
        @(posedge sys_clk);
        tx_packet_done <= 1'b1;
        @(posedge sys_clk);
        tx_packet_done <= 1'b0;
    endtask
    task automatic rx_pulse(input logic skip);
        @(posedge sys_clk);
        packet_received <= 1'b1;
        rx_skip_ack <= skip;
        @(posedge sys_clk);
        packet_received <= 1'b0;
    endtask

    always @(posedge sys_clk)
    begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == 20000)
        begin
            num_errors++;
            test_done();
        end
    end

    initial
    begin
        {sys_clk, rst_b, reg_wr, reg_rd, radio_enable, tx_packet_done, tx_skip_ack} = 7'h00;
        {ack_received, packet_received, rx_skip_ack, reg_addr, reg_wdata} = 15'h0000;
        tx_fifo_empty = 1'b1;
        num_errors = 0;
        compares = 0;
        cycle_count = 0;
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        reg_read(CONFIG_OFFSET, CONFIG_RESET);
        reg_read(RETRY_OFFSET, RETRY_RESET);
        reg_read(STATUS_OFFSET, 8'h00);
        reg_read(4'h3, 8'h00);
        host_u.xfer(8'h81, 8'h02, rd);
        reg_read(RETRY_OFFSET, 8'h02);
        host_u.xfer(8'h00, 8'h00, rd);
        check(rd, CONFIG_RESET);
        reg_write(CONFIG_OFFSET, 8'h01);
        wait_mode(MODE_STANDBY_1, 4);
        tx_fifo_empty <= 1'b0;
        en_pulse(100);
        hold_mode(MODE_STANDBY_1, 20);
        en_pulse(CE_PULSE_CYCLES + 10);
        wait_mode(MODE_TX, 10);
        hold_mode(MODE_TX, 10);
        done_pulse();
        wait_mode(MODE_STANDBY_1, 3);
        radio_enable <= 1'b1;
        wait_mode(MODE_TX, CE_PULSE_CYCLES + 10);
        done_pulse();
        hold_mode(MODE_TX, 5);
        tx_fifo_empty <= 1'b1;
        done_pulse();
        wait_mode(MODE_STANDBY_2, 3);
        hold_mode(MODE_STANDBY_2, 10);
        tx_fifo_empty <= 1'b0;
        wait_mode(MODE_TX, 3);
        // Host drops power well inside the 4 ms transmit ceiling
        reg_write(CONFIG_OFFSET, 8'h00);
        wait_mode(MODE_POWER_DOWN, 3);
        tx_fifo_empty <= 1'b1;
        radio_enable <= 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            reg_write(CONFIG_OFFSET, k ? 8'h07 : 8'h03);
            wait_mode(MODE_STANDBY_1, 8);
            radio_enable <= 1'b1;
            wait_mode(MODE_RX, 6);
            rx_pulse(k[0]);
            hold_mode(MODE_RX, 10);
            if (k)
            begin
                rx_pulse(1'b0);
                wait_mode(MODE_TX, 3);
                done_pulse();
                wait_mode(MODE_RX, 3);
            end
            radio_enable <= 1'b0;
            wait_mode(MODE_STANDBY_1, 6);
        end
        reg_write(CONFIG_OFFSET, 8'h05);
        tx_fifo_empty <= 1'b0;
        en_pulse(CE_PULSE_CYCLES + 10);
        wait_mode(MODE_TX, 10);
        for (int k = 0; k < 2; k++)
        begin
            done_pulse();
            wait_mode(MODE_RX, 3);
            wait_mode(MODE_TX, 40);
            check({7'h00, tx_is_retry}, 8'h01);
        end
        done_pulse();
        wait_mode(MODE_STANDBY_1, 40);
        hold_mode(MODE_STANDBY_1, 30);
        reg_read(STATUS_OFFSET, 8'h29);
        check({7'h00, max_retry_hit}, 8'h01);
        reg_write(STATUS_OFFSET, 8'h08);
        reg_read(STATUS_OFFSET, 8'h21);
        check({7'h00, max_retry_hit}, 8'h00);
        en_pulse(CE_PULSE_CYCLES + 10);
        wait_mode(MODE_TX, 10);
        done_pulse();
        @(posedge sys_clk);
        ack_received <= 1'b1;
        @(posedge sys_clk);
        ack_received <= 1'b0;
        wait_mode(MODE_STANDBY_1, 3);
        reg_read(STATUS_OFFSET, 8'h01);
        reg_write(CONFIG_OFFSET, 8'h00);
        wait_mode(MODE_POWER_DOWN, 3);
        test_done();
    end
endmodule
`default_nettype wire
